// ---- verilog/css_pkg.sv ----
// Package for the clock status and source select register slice.
// Assumes a byte-wide register port with 10-bit addresses.
package css_pkg;
  localparam int ADDR_W = 10;
  localparam int DATA_W = 8;
  localparam int SEL_W = 6;
  localparam int DYN_N = 4;

  // Register offsets
  localparam logic [9:0] OFS_DIV_SEL_LO = 10'h1ba;
  localparam logic [9:0] OFS_CHAN_CTRL = 10'h1bb;
  localparam logic [9:0] OFS_LOCK_STAT = 10'h22c;
  localparam logic [9:0] OFS_HOLD_STAT = 10'h22d;
  localparam logic [9:0] OFS_MON_SEL = 10'h230;

  // Field positions
  localparam int POS_DIV_SEL_LO = 5;
  localparam int POS_PWRDN = 7;
  localparam int POS_DIV_SEL_HI = 4;
  localparam int POS_VCXO = 0;
  localparam int POS_HOLD = 3;
  localparam int POS_AUTOSEL = 2;
  localparam int POS_CAL = 0;

  // Reset values
  localparam logic [2:0] RST_DIV_SEL_LO = 3'h0;
  localparam logic [7:0] RST_CHAN_CTRL = 8'h00;
  localparam logic [5:0] RST_MON_SEL = 6'h00;

  // Monitor selector codes
  localparam logic [5:0] MON_GND = 6'h00;
  localparam logic [5:0] MON_BOTH_LOCK = 6'h01;
  localparam logic [5:0] MON_IN_LOCK = 6'h02;
  localparam logic [5:0] MON_OUT_LOCK = 6'h03;
  localparam logic [5:0] MON_REFS_LOST = 6'h04;
  localparam logic [5:0] MON_LOST_LOCK = 6'h05;
  localparam logic [5:0] MON_AUTO_SEC = 6'h06;
  localparam logic [5:0] MON_PRI_OK = 6'h07;
  localparam logic [5:0] MON_SEC_OK = 6'h08;
  localparam logic [5:0] MON_TEST_OK = 6'h09;
  localparam logic [5:0] MON_VCXO_OK = 6'h0a;
  localparam logic [5:0] MON_FB_OK = 6'h0b;
  localparam logic [5:0] MON_OREF_OK = 6'h0c;
  localparam logic [5:0] MON_REFS_OK = 6'h0e;
  localparam logic [5:0] MON_ALL_OK = 6'h0f;
  localparam logic [5:0] MON_DYN_BASE = 6'h10;
  localparam logic [5:0] MON_DYN_LAST = 6'h13;

  typedef struct packed {
    logic output_pll_ref_ok;
    logic output_pll_fb_ok;
    logic vcxo_ok;
    logic test_ref_ok;
    logic secondary_reference_ok;
    logic primary_reference_ok;
    logic output_pll_locked;
    logic input_pll_locked;
    logic input_pll_fb_ok;
    logic holdover;
    logic secondary_auto_selected;
    logic vco_cal_busy;
  } css_flags_t;

  // Index 0 feedback, 1 down pulse, 2 reference, 3 up pulse
  typedef logic [3:0] css_dyn_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [9:0] addr;
    logic [7:0] wdata;
  } css_req_t;

  typedef struct packed {
    logic [2:0] div_sel_lo;
    logic [7:0] chan_ctrl;
    logic [5:0] mon_sel;
    logic [3:0] dyn_prev;
    logic [3:0] dyn_half;
    logic pin;
    logic [7:0] rd_data;
    logic rd_valid;
  } css_state_t;
endpackage

// ---- verilog/css_regs.sv ----
// Clock source select controls, readback flags and status pin selector.
// Assumes the serial control port delivers decoded byte accesses in
// this clock domain and that all flag inputs are synchronous to clk.
//
// Behaviour
// - Control bit 7 powers down input PLL driver
// - Bits 6:4 pick divider for channels 9:7
// - Bits 3:0 route VCXO to channels 3:0
// - First readback bits 7:2 show clock presence
// - First readback bits 1:0 show PLL locks
// - Second readback bit 3 shows holdover
// - Second readback bit 2 shows auto-chosen reference
// - Bit 0 shows calibration; other bits reserved
// - Six-bit selector drives status pin; zero grounds
// - Codes 1-3 show lock conditions
// - Codes 4-5 show lost references
// - Code 6 auto-select, 7-12 presence flags
// - Code 13 reserved, 14-15 combined presence
// - Codes 16-19 halved dynamics, 20-63 ground
// - Preceding register bits 7:5 pick divider, channels 6:4
`timescale 1ns/1ps

module css_regs (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire css_pkg::css_req_t req,
  input wire css_pkg::css_flags_t flags,
  input wire css_pkg::css_dyn_t dyn,
  output logic input_pll_out_powerdown,
  output logic [5:0] channel_divider_source_select,
  output logic [3:0] vcxo_route,
  output logic status_pin_zero,
  output logic [7:0] rd_data,
  output logic rd_valid
);
  css_pkg::css_state_t q;
  css_pkg::css_state_t next_q;
  logic [7:0] lock_word;
  logic [7:0] hold_word;
  logic [7:0] ctrl_word;
  logic [7:0] sel_lo_word;
  logic [7:0] mon_word;
  logic mon_level;
  logic [5:0] dyn_idx;

  always_comb begin
    lock_word = {flags.output_pll_ref_ok,
                 flags.output_pll_fb_ok,
                 flags.vcxo_ok,
                 flags.test_ref_ok,
                 flags.secondary_reference_ok,
                 flags.primary_reference_ok,
                 flags.output_pll_locked,
                 flags.input_pll_locked};
    hold_word = 8'h00;
    hold_word[css_pkg::POS_HOLD] = flags.holdover;
    hold_word[css_pkg::POS_AUTOSEL] = flags.secondary_auto_selected;
    hold_word[css_pkg::POS_CAL] = flags.vco_cal_busy;
    ctrl_word = q.chan_ctrl;
    sel_lo_word = 8'h00;
    sel_lo_word[css_pkg::POS_DIV_SEL_LO +: 3] = q.div_sel_lo;
    mon_word = {2'h0, q.mon_sel};
  end

  // Monitor source for the current selector
  always_comb begin
    dyn_idx = q.mon_sel - css_pkg::MON_DYN_BASE;
    case (q.mon_sel)
      css_pkg::MON_GND: mon_level = 1'b0;
      css_pkg::MON_BOTH_LOCK: begin
        mon_level = flags.input_pll_locked & flags.output_pll_locked;
      end
      css_pkg::MON_IN_LOCK: mon_level = flags.input_pll_locked;
      css_pkg::MON_OUT_LOCK: mon_level = flags.output_pll_locked;
      css_pkg::MON_REFS_LOST: begin
        mon_level = ~flags.primary_reference_ok &
                    ~flags.secondary_reference_ok;
      end
      css_pkg::MON_LOST_LOCK: begin
        mon_level = ~flags.primary_reference_ok &
                    ~flags.secondary_reference_ok &
                    flags.output_pll_locked;
      end
      css_pkg::MON_AUTO_SEC: mon_level = flags.secondary_auto_selected;
      css_pkg::MON_PRI_OK: mon_level = flags.primary_reference_ok;
      css_pkg::MON_SEC_OK: mon_level = flags.secondary_reference_ok;
      css_pkg::MON_TEST_OK: mon_level = flags.test_ref_ok;
      css_pkg::MON_VCXO_OK: mon_level = flags.vcxo_ok;
      css_pkg::MON_FB_OK: mon_level = flags.input_pll_fb_ok;
      css_pkg::MON_OREF_OK: mon_level = flags.output_pll_ref_ok;
      css_pkg::MON_REFS_OK: begin
        mon_level = flags.primary_reference_ok &
                    flags.secondary_reference_ok;
      end
      css_pkg::MON_ALL_OK: begin
        mon_level = flags.primary_reference_ok &
                    flags.secondary_reference_ok &
                    flags.vcxo_ok &
                    flags.input_pll_fb_ok &
                    flags.output_pll_ref_ok &
                    flags.output_pll_fb_ok;
      end
      default: begin
        // Reserved code 13 and 20 upward ground the pin
        if (q.mon_sel >= css_pkg::MON_DYN_BASE &&
            q.mon_sel <= css_pkg::MON_DYN_LAST) begin
          mon_level = q.dyn_half[dyn_idx[1:0]];
        end else begin
          mon_level = 1'b0;
        end
      end
    endcase
  end

  always_comb begin
    next_q = q;
    if (clk_en) begin
      // Halving by toggling on each rising edge keeps the pin slow enough
      // to be observed; sampling at clk limits this to sub-half-rate inputs
      for (int i = 0; i < css_pkg::DYN_N; i++) begin
        if (dyn[i] && !q.dyn_prev[i]) begin
          next_q.dyn_half[i] = ~q.dyn_half[i];
        end
      end
      next_q.dyn_prev = dyn;
      next_q.pin = mon_level;
      if (req.wr) begin
        case (req.addr)
          css_pkg::OFS_DIV_SEL_LO: begin
            next_q.div_sel_lo = req.wdata[css_pkg::POS_DIV_SEL_LO +: 3];
          end
          css_pkg::OFS_CHAN_CTRL: next_q.chan_ctrl = req.wdata;
          css_pkg::OFS_MON_SEL: begin
            next_q.mon_sel = req.wdata[css_pkg::SEL_W-1:0];
          end
          default: next_q.chan_ctrl = q.chan_ctrl;
        endcase
      end
      next_q.rd_valid = req.rd;
      if (req.rd) begin
        case (req.addr)
          css_pkg::OFS_DIV_SEL_LO: next_q.rd_data = sel_lo_word;
          css_pkg::OFS_CHAN_CTRL: next_q.rd_data = ctrl_word;
          css_pkg::OFS_LOCK_STAT: next_q.rd_data = lock_word;
          css_pkg::OFS_HOLD_STAT: next_q.rd_data = hold_word;
          css_pkg::OFS_MON_SEL: next_q.rd_data = mon_word;
          default: next_q.rd_data = 8'h00;
        endcase
      end else begin
        next_q.rd_data = 8'h00;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      q.div_sel_lo <= css_pkg::RST_DIV_SEL_LO;
      q.chan_ctrl <= css_pkg::RST_CHAN_CTRL;
      q.mon_sel <= css_pkg::RST_MON_SEL;
      q.dyn_prev <= 4'h0;
      q.dyn_half <= 4'h0;
      q.pin <= 1'b0;
      q.rd_data <= 8'h00;
      q.rd_valid <= 1'b0;
    end else begin
      q <= next_q;
    end
  end

  assign input_pll_out_powerdown = q.chan_ctrl[css_pkg::POS_PWRDN];
  assign channel_divider_source_select = {
    q.chan_ctrl[css_pkg::POS_DIV_SEL_HI +: 3], q.div_sel_lo};
  assign vcxo_route = q.chan_ctrl[css_pkg::POS_VCXO +: 4];
  assign status_pin_zero = q.pin;
  assign rd_data = q.rd_data;
  assign rd_valid = q.rd_valid;

  a_pwrdn_write: assert property (
    @(posedge clk) disable iff (!rst_b)
    clk_en && req.wr && req.addr == css_pkg::OFS_CHAN_CTRL
    |=> input_pll_out_powerdown == $past(req.wdata[7]))
    else $error("power-down bit did not follow write");

  a_hi_div_sel: assert property (
    @(posedge clk) disable iff (!rst_b)
    clk_en && req.wr && req.addr == css_pkg::OFS_CHAN_CTRL
    |=> channel_divider_source_select[5:3] == $past(req.wdata[6:4]))
    else $error("channels 9 to 7 select did not follow write");

  a_vcxo_route: assert property (
    @(posedge clk) disable iff (!rst_b)
    clk_en && req.wr && req.addr == css_pkg::OFS_CHAN_CTRL
    |=> vcxo_route == $past(req.wdata[3:0]))
    else $error("VCXO routing did not follow write");

  a_lo_div_sel: assert property (
    @(posedge clk) disable iff (!rst_b)
    clk_en && req.wr && req.addr == css_pkg::OFS_DIV_SEL_LO
    |=> channel_divider_source_select[2:0] == $past(req.wdata[7:5]))
    else $error("channels 6 to 4 select did not follow write");

  a_lock_read: assert property (
    @(posedge clk) disable iff (!rst_b)
    clk_en && req.rd && req.addr == css_pkg::OFS_LOCK_STAT
    |=> rd_valid && rd_data == {$past(flags.output_pll_ref_ok),
      $past(flags.output_pll_fb_ok), $past(flags.vcxo_ok),
      $past(flags.test_ref_ok), $past(flags.secondary_reference_ok),
      $past(flags.primary_reference_ok), $past(flags.output_pll_locked),
      $past(flags.input_pll_locked)})
    else $error("first readback does not match flags");

  a_hold_read: assert property (
    @(posedge clk) disable iff (!rst_b)
    clk_en && req.rd && req.addr == css_pkg::OFS_HOLD_STAT
    |=> rd_data[3] == $past(flags.holdover) &&
        rd_data[2] == $past(flags.secondary_auto_selected) &&
        rd_data[0] == $past(flags.vco_cal_busy) &&
        rd_data[7:4] == 4'h0 && !rd_data[1])
    else $error("second readback does not match flags");

  a_ro_ignored: assert property (
    @(posedge clk) disable iff (!rst_b)
    clk_en && req.wr && (req.addr == css_pkg::OFS_LOCK_STAT ||
      req.addr == css_pkg::OFS_HOLD_STAT)
    |=> $stable(q.chan_ctrl) && $stable(q.mon_sel) && $stable(q.div_sel_lo))
    else $error("write to readback register changed state");

  a_pin_gnd: assert property (
    @(posedge clk) disable iff (!rst_b)
    clk_en && q.mon_sel == css_pkg::MON_GND |=> !status_pin_zero)
    else $error("status pin not grounded for code zero");

  a_pin_both_lock: assert property (
    @(posedge clk) disable iff (!rst_b)
    clk_en && q.mon_sel == css_pkg::MON_BOTH_LOCK
    |=> status_pin_zero ==
        $past(flags.input_pll_locked && flags.output_pll_locked))
    else $error("status pin wrong for both-locked code");

  a_pin_refs_lost: assert property (
    @(posedge clk) disable iff (!rst_b)
    clk_en && q.mon_sel == css_pkg::MON_REFS_LOST
    |=> status_pin_zero == $past(!flags.primary_reference_ok &&
        !flags.secondary_reference_ok))
    else $error("status pin wrong for lost references code");

  a_pin_vcxo: assert property (
    @(posedge clk) disable iff (!rst_b)
    clk_en && q.mon_sel == css_pkg::MON_VCXO_OK
    |=> status_pin_zero == $past(flags.vcxo_ok))
    else $error("status pin wrong for VCXO code");

  a_pin_reserved: assert property (
    @(posedge clk) disable iff (!rst_b)
    clk_en && (q.mon_sel == 6'h0d || q.mon_sel > css_pkg::MON_DYN_LAST)
    |=> !status_pin_zero)
    else $error("status pin not grounded for reserved code");

  a_pin_halved: assert property (
    @(posedge clk) disable iff (!rst_b)
    clk_en && q.mon_sel == css_pkg::MON_DYN_BASE && dyn[0] && !q.dyn_prev[0]
    ##1 clk_en && q.mon_sel == css_pkg::MON_DYN_BASE
    |=> status_pin_zero != $past(status_pin_zero, 2))
    else $error("halved feedback did not toggle on rising edge");
endmodule

// ---- verification/clock_status_and_source_select_tb.sv ----
// Self-checking bench for the clock status and source select registers.
// Assumes css_pkg and css_regs are compiled first; inputs move on falling edges.
`timescale 1ns/1ps

module clock_status_and_source_select_tb;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic clk_en = 1'b1;
  css_pkg::css_req_t req = '0;
  css_pkg::css_flags_t flags = '0;
  css_pkg::css_dyn_t dyn = '0;
  logic input_pll_out_powerdown;
  logic [5:0] channel_divider_source_select;
  logic [3:0] vcxo_route;
  logic status_pin_zero;
  logic [7:0] rd_data;
  logic rd_valid;
  int num_errors = 0;
  int tests_run = 0;

  css_regs dut_u (
    .clk(clk),
    .rst_b(rst_b),
    .clk_en(clk_en),
    .req(req),
    .flags(flags),
    .dyn(dyn),
    .input_pll_out_powerdown(input_pll_out_powerdown),
    .channel_divider_source_select(channel_divider_source_select),
    .vcxo_route(vcxo_route),
    .status_pin_zero(status_pin_zero),
    .rd_data(rd_data),
    .rd_valid(rd_valid)
  );

  always #50 clk = ~clk;

  task automatic report_and_stop;
    $display("errors %0d, checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One-cycle write strobe, then one idle edge so a following call never
  // lowers and raises the strobe in the same time step
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    req.wr = 1'b1;
    req.addr = a;
    req.wdata = d;
    @(negedge clk);
    req.wr = 1'b0;
    @(negedge clk);
  endtask

  task automatic rd(input logic [9:0] a, input logic [7:0] e, input string what);
    req.rd = 1'b1;
    req.addr = a;
    @(negedge clk);
    req.rd = 1'b0;
    chk("rd_valid", 8'h01, {7'h0, rd_valid});
    chk(what, e, rd_data);
    // Read answer stands one cycle only
    @(negedge clk);
    chk("rd_valid after", 8'h00, {7'h0, rd_valid});
    chk("rd_data after", 8'h00, rd_data);
  endtask

  // Pin levels for the static selector codes; reserved codes ground the pin
  function automatic logic mon_exp(input int c, input css_pkg::css_flags_t f);
    case (c)
      1: return f.input_pll_locked & f.output_pll_locked;
      2: return f.input_pll_locked;
      3: return f.output_pll_locked;
      4: return !f.primary_reference_ok && !f.secondary_reference_ok;
      5: return !f.primary_reference_ok && !f.secondary_reference_ok && f.output_pll_locked;
      6: return f.secondary_auto_selected;
      7: return f.primary_reference_ok;
      8: return f.secondary_reference_ok;
      9: return f.test_ref_ok;
      10: return f.vcxo_ok;
      11: return f.input_pll_fb_ok;
      12: return f.output_pll_ref_ok;
      14: return f.primary_reference_ok & f.secondary_reference_ok;
      15: return f.primary_reference_ok & f.secondary_reference_ok & f.vcxo_ok &
          f.input_pll_fb_ok & f.output_pll_ref_ok & f.output_pll_fb_ok;
      default: return 1'b0;
    endcase
  endfunction

  task automatic t_reset;
    chk("outputs after reset", 8'h00, {input_pll_out_powerdown, vcxo_route, status_pin_zero, 2'h0});
    rd(css_pkg::OFS_CHAN_CTRL, 8'h00, "chan ctrl reset");
    rd(css_pkg::OFS_DIV_SEL_LO, 8'h00, "div sel reset");
    rd(css_pkg::OFS_MON_SEL, 8'h00, "mon sel reset");
  endtask

  task automatic t_control;
    logic [7:0] v[2] = '{8'ha5, 8'h5a};
    foreach (v[i]) begin
      wr(css_pkg::OFS_CHAN_CTRL, v[i]);
      chk("powerdown", {7'h0, v[i][7]}, {7'h0, input_pll_out_powerdown});
      chk("div sel hi", {5'h0, v[i][6:4]}, {5'h0, channel_divider_source_select[5:3]});
      chk("vcxo route", {4'h0, v[i][3:0]}, {4'h0, vcxo_route});
      rd(css_pkg::OFS_CHAN_CTRL, v[i], "chan ctrl");
    end
    wr(css_pkg::OFS_DIV_SEL_LO, 8'hbf);
    chk("div sel lo", 8'h05, {5'h0, channel_divider_source_select[2:0]});
    rd(css_pkg::OFS_DIV_SEL_LO, 8'ha0, "div sel readback");
    wr(css_pkg::OFS_MON_SEL, 8'hd7);
    rd(css_pkg::OFS_MON_SEL, 8'h17, "mon sel readback");
    wr(10'h100, 8'hff);
    rd(10'h100, 8'h00, "unmapped read");
    // Held enable low: the write below must be lost
    clk_en = 1'b0;
    wr(css_pkg::OFS_CHAN_CTRL, 8'h00);
    clk_en = 1'b1;
    chk("frozen vcxo route", 8'h0a, {4'h0, vcxo_route});
  endtask

  task automatic t_readback;
    for (int p = 0; p < 14; p++) begin
      flags = p < 12 ? css_pkg::css_flags_t'(12'h001 << p) : (p == 12 ? '1 : '0);
      rd(css_pkg::OFS_LOCK_STAT, flags[11:4], "lock status");
      rd(css_pkg::OFS_HOLD_STAT, {4'h0, flags[2:1], 1'b0, flags[0]}, "hold status");
    end
    wr(css_pkg::OFS_LOCK_STAT, 8'hff);
    wr(css_pkg::OFS_HOLD_STAT, 8'hff);
    rd(css_pkg::OFS_LOCK_STAT, 8'h00, "lock status write");
    rd(css_pkg::OFS_HOLD_STAT, 8'h00, "hold status write");
  endtask

  // Walking one, walking zero, all clear and all set for static codes 0-15 and 20-23
  task automatic t_monitor;
    for (int c = 0; c < 24; c++) begin
      if (c < 16 || c > 19) begin
        wr(css_pkg::OFS_MON_SEL, 8'(c));
        for (int p = 0; p < 26; p++) begin
          flags = p < 12 ? css_pkg::css_flags_t'(12'h001 << p) :
              p < 24 ? css_pkg::css_flags_t'(~(12'h001 << (p - 12))) : (p == 24 ? '0 : '1);
          @(negedge clk);
          chk($sformatf("pin code %0d", c), {7'h0, mon_exp(c, flags)}, {7'h0, status_pin_zero});
        end
      end
    end
  endtask

  task automatic t_dynamic;
    logic [3:0] tog = 4'h0;
    for (int k = 0; k < 4; k++) begin
      wr(css_pkg::OFS_MON_SEL, 8'(16 + k));
      for (int p = 0; p < 3; p++) begin
        dyn[k] = 1'b1;
        @(negedge clk);
        @(negedge clk);
        dyn[k] = 1'b0;
        tog[k] = ~tog[k];
        @(negedge clk);
        chk($sformatf("halved signal %0d", k), {7'h0, tog[k]}, {7'h0, status_pin_zero});
      end
    end
    // Every toggle now ends high, so a ground code that leaked one would show it
    for (int k = 0; k < 4; k++) begin
      wr(css_pkg::OFS_MON_SEL, 8'(20 + k));
      chk($sformatf("ground code %0d", 20 + k), 8'h00, {7'h0, status_pin_zero});
    end
  endtask

  initial begin
    repeat (100000) @(posedge clk);
    num_errors++;
    report_and_stop();
  end

  initial begin
    repeat (20) @(negedge clk);
    rst_b = 1'b1;
    @(negedge clk);
    t_reset();
    t_control();
    t_readback();
    t_monitor();
    t_dynamic();
    report_and_stop();
  end
endmodule
